/* smc_cfg.svh */
`ifndef SMC_CFG_SVH
`define SMC_CFG_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define SMC_PWR_OFF        8'h00
`define SMC_FILT_OFF       8'h04
`define SMC_CLKC_OFF       8'h08
`define SMC_STAT_OFF       8'h0C

// ****************************************************************
// Field positions
// ****************************************************************
`define SMC_PWR_STOP_BIT   0
`define SMC_PWR_MASK0_BIT  1
`define SMC_PWR_MASK1_BIT  2
`define SMC_PWR_MASKI_BIT  3
`define SMC_FILT_EN_BIT    0
`define SMC_CLKC_SRC_BIT   3
`define SMC_STAT_INVAL_BIT 3

// ****************************************************************
// Reset values and encodings
// ****************************************************************
`define SMC_PWR_RST        3'h0
`define SMC_FILT_RST       4'h0
`define SMC_CLKC_RST       4'h3
`define SMC_FILT_SLOW_MIN  3'h3
`define SMC_RESP_OKAY      2'h0
`define SMC_RESP_SLVERR    2'h2

// ****************************************************************
// Clock rates and timing
// ****************************************************************
`define SMC_FXX_HZ         20000000
`define SMC_SUB_HZ         32768
`define SMC_SUB_RATIO      4
`define SMC_CLK_PERIOD_NS  50
`define SMC_OSC_SETTLE_NS  1000
`define SMC_SETTLE_CYC     ((`SMC_OSC_SETTLE_NS + `SMC_CLK_PERIOD_NS - 1) / `SMC_CLK_PERIOD_NS)

`endif

/* smc_ctrl.sv */
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "smc_cfg.svh"
module smc_ctrl
   import smc_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        nmi0_req,
   input  wire logic        nmi1_req,
   input  wire logic        irq_req,
   input  wire logic        external_irq_line_three,
   input  wire logic        adc_running,
   output logic             clk_stop,
   output logic             cpu_hold,
   output logic             adc_halt,
   output logic             irq_dispatch,
   output logic             clock_source_select_bit,
   output logic [2:0]       cpu_clock_divider_field
);

   // ****************************************************************
   // Helpers
   // ****************************************************************

   // True when the divided main clock is more than four times the subclock.
   function automatic logic ratio_ok(input logic [2:0] div);
      ratio_ok = (`SMC_FXX_HZ >> div) > (`SMC_SUB_HZ * `SMC_SUB_RATIO);
   endfunction

   localparam logic [4:0] SETTLE_LAST = 5'(`SMC_SETTLE_CYC - 1);

   smc_state_t  st_q, st_d;
   logic [4:0]  cnt_q;
   logic [2:0]  pwr_q;
   logic [3:0]  filt_q;
   logic [3:0]  clkc_q;
   logic        inval_q;
   logic        clk_stop_q, cpu_hold_q, adc_halt_q, dispatch_q;
   logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic        aw_hold_q, w_hold_q;
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   logic [1:0]  bresp_q, rresp_q;
   logic [31:0] rdata_q;
   logic        line3_s;

   smc_sync2 u_line3_sync (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .async_in (external_irq_line_three),
      .sync_out (line3_s)
   );

   // ****************************************************************
   // Wake-up qualification
   // ****************************************************************

   // A slow filter clock cannot sample the line while the clock is stopped.
   wire slow_filter = filt_q[`SMC_FILT_EN_BIT] && (filt_q[3:1] >= `SMC_FILT_SLOW_MIN);
   wire wake_nmi0   = nmi0_req && !pwr_q[`SMC_PWR_MASK0_BIT - 1];
   wire wake_nmi1   = nmi1_req && !pwr_q[`SMC_PWR_MASK1_BIT - 1];
   wire wake_irq    = irq_req && !pwr_q[`SMC_PWR_MASKI_BIT - 1];
   wire wake_line3  = line3_s && !pwr_q[`SMC_PWR_MASKI_BIT - 1] && !slow_filter;
   wire wake_any    = wake_nmi0 || wake_nmi1 || wake_irq || wake_line3;

   // ****************************************************************
   // Register write decode
   // ****************************************************************

   // Control bits sit in byte lane 0, so only that strobe commits a write.
   wire wr_fire  = aw_hold_q && w_hold_q && !bvalid_q;
   wire wr_lane  = wr_fire && wstrb_q[0];
   wire wr_pwr   = wr_lane && (awaddr_q == `SMC_PWR_OFF);
   wire wr_filt  = wr_lane && (awaddr_q == `SMC_FILT_OFF);
   wire wr_clkc  = wr_lane && (awaddr_q == `SMC_CLKC_OFF);
   wire wr_stat  = wr_lane && (awaddr_q == `SMC_STAT_OFF);
   wire wr_map   = (awaddr_q == `SMC_PWR_OFF) || (awaddr_q == `SMC_FILT_OFF) ||
                   (awaddr_q == `SMC_CLKC_OFF) || (awaddr_q == `SMC_STAT_OFF);
   wire stop_wr  = wr_pwr && wdata_q[`SMC_PWR_STOP_BIT];
   // A subclock switch is refused unless the new divider leaves enough margin.
   wire src_ok   = !wdata_q[`SMC_CLKC_SRC_BIT] || ratio_ok(wdata_q[2:0]);
   wire inval_set = (st_q == SMC_RUN) && stop_wr && !wake_any && adc_running;
   wire inval_clr = wr_stat && wdata_q[`SMC_STAT_INVAL_BIT];

   // ****************************************************************
   // Register read decode
   // ****************************************************************
   wire [3:0] stat_word = {inval_q, clkc_q[`SMC_CLKC_SRC_BIT], adc_halt_q, st_q != SMC_RUN};
   wire       rd_map    = (s_axi_araddr == `SMC_PWR_OFF) || (s_axi_araddr == `SMC_FILT_OFF) ||
                          (s_axi_araddr == `SMC_CLKC_OFF) || (s_axi_araddr == `SMC_STAT_OFF);
   wire [31:0] rd_word  =
      (s_axi_araddr == `SMC_PWR_OFF)  ? {28'h000_0000, pwr_q, 1'b0} :
      (s_axi_araddr == `SMC_FILT_OFF) ? {28'h000_0000, filt_q} :
      (s_axi_araddr == `SMC_CLKC_OFF) ? {28'h000_0000, clkc_q} :
      (s_axi_araddr == `SMC_STAT_OFF) ? {28'h000_0000, stat_word} : 32'h0000_0000;

   // ****************************************************************
   // Standby sequencer
   // ****************************************************************

   // Next state; a pending wake source at the stop store keeps the core running.
   always_comb begin
      st_d = st_q;
      case (st_q)
         SMC_RUN:  if (stop_wr && !wake_any) st_d = SMC_STOP;
         SMC_STOP: if (wake_any) st_d = SMC_WAKE;
         SMC_WAKE: if (cnt_q == SETTLE_LAST) st_d = SMC_RUN;
         default:  st_d = SMC_RUN;
      endcase
   end

   // The converter is halted and powered down for the whole stop interval.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q       <= SMC_RUN;
         cnt_q      <= 5'h00;
         clk_stop_q <= 1'b0;
         cpu_hold_q <= 1'b0;
         adc_halt_q <= 1'b0;
         dispatch_q <= 1'b0;
      end else begin
         st_q       <= st_d;
         cnt_q      <= (st_q == SMC_WAKE) ? cnt_q + 5'h01 : 5'h00;
         clk_stop_q <= (st_d == SMC_STOP);
         cpu_hold_q <= (st_d != SMC_RUN);
         if ((st_q == SMC_RUN) && (st_d == SMC_STOP))
            adc_halt_q <= adc_running;
         else if (st_d == SMC_RUN)
            adc_halt_q <= 1'b0;
         dispatch_q <= ((st_q == SMC_RUN) && stop_wr && wake_any) ||
                       ((st_q == SMC_WAKE) && (st_d == SMC_RUN));
      end
   end

   // ****************************************************************
   // Control registers
   // ****************************************************************

   // The invalid-result flag: a new stop entry beats a same-cycle clear.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pwr_q   <= `SMC_PWR_RST;
         filt_q  <= `SMC_FILT_RST;
         clkc_q  <= `SMC_CLKC_RST;
         inval_q <= 1'b0;
      end else begin
         if (wr_pwr) pwr_q <= wdata_q[3:1];
         if (wr_filt) filt_q <= wdata_q[3:0];
         if (wr_clkc && src_ok) clkc_q <= wdata_q[3:0];
         if (inval_set) inval_q <= 1'b1;
         else if (inval_clr) inval_q <= 1'b0;
      end
   end

   // ****************************************************************
   // AXI4-Lite slave
   // ****************************************************************

   // Address and data are latched independently; one write at a time.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `SMC_RESP_OKAY;
         awaddr_q  <= 8'h00;
         wdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
      end else begin
         if (s_axi_awvalid && awready_q) begin
            awaddr_q  <= s_axi_awaddr;
            aw_hold_q <= 1'b1;
            awready_q <= 1'b0;
         end
         if (s_axi_wvalid && wready_q) begin
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
            w_hold_q <= 1'b1;
            wready_q <= 1'b0;
         end
         if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_map ? `SMC_RESP_OKAY : `SMC_RESP_SLVERR;
         end
         if (bvalid_q && s_axi_bready) begin
            bvalid_q  <= 1'b0;
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
         end
      end
   end

   // Reads answer one cycle after the address is taken.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= `SMC_RESP_OKAY;
      end else if (s_axi_arvalid && arready_q) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rdata_q   <= rd_word;
         rresp_q   <= rd_map ? `SMC_RESP_OKAY : `SMC_RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
      end
   end

   assign s_axi_awready           = awready_q;
   assign s_axi_wready            = wready_q;
   assign s_axi_bvalid            = bvalid_q;
   assign s_axi_bresp             = bresp_q;
   assign s_axi_arready           = arready_q;
   assign s_axi_rvalid            = rvalid_q;
   assign s_axi_rdata             = rdata_q;
   assign s_axi_rresp             = rresp_q;
   assign clk_stop                = clk_stop_q;
   assign cpu_hold                = cpu_hold_q;
   assign adc_halt                = adc_halt_q;
   assign irq_dispatch            = dispatch_q;
   assign clock_source_select_bit = clkc_q[`SMC_CLKC_SRC_BIT];
   assign cpu_clock_divider_field = clkc_q[2:0];

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   pend_cancel_a: assert property (
      (st_q == SMC_RUN) && stop_wr && wake_any |=> (st_q == SMC_RUN) && dispatch_q && !clk_stop_q)
      else $error("Pending request did not cancel stop entry.");
   mask_hold_a: assert property (
      (st_q == SMC_STOP) && !wake_any |=> (st_q == SMC_STOP) && clk_stop_q)
      else $error("Stop released without an unmasked source.");
   nmi_mask_a: assert property (
      (st_q == SMC_STOP) && nmi0_req && pwr_q[0] && !nmi1_req && !irq_req && !line3_s
      |=> (st_q == SMC_STOP))
      else $error("Masked first NMI woke the device.");
   slow_filter_a: assert property (
      (st_q == SMC_STOP) && line3_s && slow_filter && !nmi0_req && !nmi1_req && !irq_req
      |=> (st_q == SMC_STOP))
      else $error("Line three woke through a slow filter.");
   adc_stop_a: assert property (
      (st_q == SMC_RUN) && stop_wr && !wake_any && adc_running |=> adc_halt_q && clk_stop_q)
      else $error("Converter not halted at stop entry.");
   adc_power_a: assert property (
      (st_q == SMC_STOP) && adc_halt_q |=> adc_halt_q)
      else $error("Converter power restored during stop.");
   adc_resume_a: assert property (
      $fell(adc_halt_q) |-> (st_q == SMC_RUN) && dispatch_q)
      else $error("Converter resumed outside stop release.");
   wake_order_a: assert property (
      (st_q == SMC_STOP) && wake_any |=> !clk_stop_q ##20 (st_q == SMC_RUN) && dispatch_q)
      else $error("Wake sequence length or order wrong.");
   dispatch_run_a: assert property (
      dispatch_q |-> (st_q == SMC_RUN) && !clk_stop_q && !cpu_hold_q)
      else $error("Interrupt dispatched before clock restored.");

   stop_entry_c: cover property ((st_q == SMC_RUN) ##1 (st_q == SMC_STOP));
   stop_cancel_c: cover property ((st_q == SMC_RUN) && stop_wr && wake_any);
   wake_done_c: cover property ((st_q == SMC_WAKE) ##1 (st_q == SMC_RUN) && dispatch_q);
   adc_cycle_c: cover property ($rose(adc_halt_q) ##[1:100] $fell(adc_halt_q));

endmodule

/* smc_ctrl_bench.sv */
`timescale 1ns/1ns
`include "smc_cfg.svh"
module smc_ctrl_bench;
   logic        aclk, aresetn, adc_start;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb, raise, pend_q;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, adc_running;
   logic        nmi0_req, nmi1_req, irq_req, external_irq_line_three;
   logic        clk_stop, cpu_hold, adc_halt, irq_dispatch, clock_source_select_bit;
   logic [2:0]  cpu_clock_divider_field;
   int          errors = 0, compares = 0, disp_n = 0, n, d0;

   // ****************************************************************
   // Design, partner and clock
   // ****************************************************************
   smc_ctrl u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .nmi0_req, .nmi1_req, .irq_req,
      .external_irq_line_three, .adc_running, .clk_stop, .cpu_hold, .adc_halt,
      .irq_dispatch, .clock_source_select_bit, .cpu_clock_divider_field);
   smc_irq_model u_model (.aclk, .aresetn, .raise, .adc_start, .irq_dispatch, .adc_halt,
      .pend_q, .adc_running);
   assign {external_irq_line_three, irq_req, nmi1_req, nmi0_req} = pend_q;

   // The clock toggles every 25 ns, half the period of 50 ns.
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   // Dispatch pulses are counted as sampled, so a one-cycle pulse is never missed.
   always @(posedge aclk) begin
      if (irq_dispatch === 1'b1) disp_n++;
   end

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Address and data go out together; each is dropped once taken.
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] r);
      n = 0;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 50);
      s_axi_bready <= 1'b0;
      chk({s_axi_bvalid, s_axi_bresp}, {1'b1, r});
      @(posedge aclk);
   endtask

   task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      n = 0;
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 50);
      s_axi_rready <= 1'b0;
      chk({s_axi_rvalid, s_axi_rresp}, {1'b1, r});
      chk(s_axi_rdata, d);
      @(posedge aclk);
   endtask

   task automatic rst();
      aresetn       <= 1'b0;
      raise         <= 4'h0;
      adc_start     <= 1'b0;
      s_axi_awaddr  <= 8'h00;
      s_axi_wdata   <= 32'h0000_0000;
      s_axi_wstrb   <= 4'h0;
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid  <= 1'b0;
      s_axi_bready  <= 1'b0;
      s_axi_araddr  <= 8'h00;
      s_axi_arvalid <= 1'b0;
      s_axi_rready  <= 1'b0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
   endtask

   // Software idles after the stop store before anything else.
   task automatic stop(input logic [3:0] m);
      axw(`SMC_PWR_OFF, {28'h000_0000, m | 4'h1}, 4'h1, `SMC_RESP_OKAY);
      repeat (5) @(posedge aclk);
   endtask

   task automatic pulse(input logic [3:0] r);
      raise <= r;
      @(posedge aclk);
      raise <= 4'h0;
   endtask

   task automatic final_report();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // The scenarios take well under a thousand cycles; a hang ends here.
   initial begin
      repeat (5000) @(posedge aclk);
      errors++;
      final_report();
   end

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   initial begin
      rst();
      chk({clk_stop, cpu_hold, adc_halt, irq_dispatch, clock_source_select_bit,
           cpu_clock_divider_field}, 32'h0000_0003);
      chk({s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid},
          32'h0000_001C);
      axr(`SMC_PWR_OFF, 32'h0000_0000, `SMC_RESP_OKAY);
      axr(`SMC_CLKC_OFF, 32'h0000_0003, `SMC_RESP_OKAY);
      axw(`SMC_FILT_OFF, 32'h0000_0005, 4'h1, `SMC_RESP_OKAY);
      axr(`SMC_FILT_OFF, 32'h0000_0005, `SMC_RESP_OKAY);
      axw(`SMC_FILT_OFF, 32'h0000_000F, 4'h2, `SMC_RESP_OKAY);
      axr(`SMC_FILT_OFF, 32'h0000_0005, `SMC_RESP_OKAY);
      axw(8'h10, 32'h0000_000F, 4'hF, `SMC_RESP_SLVERR);
      axr(8'h10, 32'h0000_0000, `SMC_RESP_SLVERR);
      $display("test registers done");

      // A request already pending turns the stop store into a dispatch.
      d0 = disp_n;
      pulse(4'h1);
      stop(4'h0);
      chk({clk_stop, cpu_hold, pend_q}, 32'h0000_0000);
      chk(disp_n - d0, 32'h0000_0001);
      $display("test pending cancel done");

      // Masked first NMI leaves the core stopped until the mask is lifted.
      d0 = disp_n;
      stop(4'hE);
      pulse(4'h1);
      repeat (10) @(posedge aclk);
      chk({clk_stop, cpu_hold}, 32'h0000_0003);
      axw(`SMC_PWR_OFF, 32'h0000_0000, 4'h1, `SMC_RESP_OKAY);
      repeat (25) @(posedge aclk);
      chk({clk_stop, cpu_hold, pend_q}, 32'h0000_0000);
      chk(disp_n - d0, 32'h0000_0001);
      $display("test release mask done");

      // Line three is deaf behind a slow filter, heard behind a fast one.
      d0 = disp_n;
      axw(`SMC_FILT_OFF, 32'h0000_0007, 4'h1, `SMC_RESP_OKAY);
      stop(4'h0);
      pulse(4'h8);
      repeat (10) @(posedge aclk);
      chk(clk_stop, 32'h0000_0001);
      pulse(4'h4);
      repeat (25) @(posedge aclk);
      chk({clk_stop, cpu_hold, pend_q}, 32'h0000_0000);
      axw(`SMC_FILT_OFF, 32'h0000_0005, 4'h1, `SMC_RESP_OKAY);
      stop(4'h0);
      pulse(4'h8);
      repeat (28) @(posedge aclk);
      chk({clk_stop, cpu_hold, pend_q}, 32'h0000_0000);
      chk(disp_n - d0, 32'h0000_0002);
      $display("test line three done");

      // A running converter is halted through stop and its results flagged.
      adc_start <= 1'b1;
      @(posedge aclk);
      adc_start <= 1'b0;
      stop(4'h0);
      chk({adc_halt, adc_running, clk_stop}, 32'h0000_0005);
      axr(`SMC_STAT_OFF, 32'h0000_000B, `SMC_RESP_OKAY);
      pulse(4'h4);
      repeat (25) @(posedge aclk);
      chk({adc_halt, adc_running, cpu_hold}, 32'h0000_0002);
      axr(`SMC_STAT_OFF, 32'h0000_0008, `SMC_RESP_OKAY);
      axw(`SMC_STAT_OFF, 32'h0000_0008, 4'h1, `SMC_RESP_OKAY);
      axr(`SMC_STAT_OFF, 32'h0000_0000, `SMC_RESP_OKAY);
      $display("test converter done");

      // The divider is set first, then the source bit with the divider kept.
      axw(`SMC_CLKC_OFF, 32'h0000_0002, 4'h1, `SMC_RESP_OKAY);
      axw(`SMC_CLKC_OFF, 32'h0000_000A, 4'h1, `SMC_RESP_OKAY);
      axr(`SMC_CLKC_OFF, 32'h0000_000A, `SMC_RESP_OKAY);
      chk({clock_source_select_bit, cpu_clock_divider_field}, 32'h0000_000A);
      axr(`SMC_STAT_OFF, 32'h0000_0004, `SMC_RESP_OKAY);
      $display("test subclock done");

      // A reset in mid-run returns every control to its idle value.
      rst();
      chk({clk_stop, cpu_hold, adc_halt, irq_dispatch, clock_source_select_bit,
           cpu_clock_divider_field}, 32'h0000_0003);
      axr(`SMC_CLKC_OFF, 32'h0000_0003, `SMC_RESP_OKAY);
      axr(`SMC_FILT_OFF, 32'h0000_0000, `SMC_RESP_OKAY);
      $display("test second reset done");
      final_report();
   end
endmodule

/* smc_irq_model.sv */
`timescale 1ns/1ns
// ****************************************************************
// Interrupt source and converter model
// ****************************************************************
module smc_irq_model (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic [3:0] raise,
   input  wire logic       adc_start,
   input  wire logic       irq_dispatch,
   input  wire logic       adc_halt,
   output logic [3:0]      pend_q,
   output logic            adc_running
);
   logic adc_on_q;

   // Requests stay pending until dispatched, so one can meet a stop write.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pend_q   <= 4'h0;
         adc_on_q <= 1'b0;
      end else begin
         pend_q   <= irq_dispatch ? raise : (pend_q | raise);
         adc_on_q <= adc_on_q | adc_start;
      end
   end

   // The converter pauses while halted and picks up again by itself.
   assign adc_running = adc_on_q & ~adc_halt;
endmodule

/* smc_pkg.sv */
package smc_pkg;

   // Standby sequencer states, one-hot.
   typedef enum logic [2:0] {
      SMC_RUN  = 3'h1,
      SMC_STOP = 3'h2,
      SMC_WAKE = 3'h4
   } smc_state_t;

endpackage

/* smc_sync2.sv */
`timescale 1ns/1ns
module smc_sync2 (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic async_in,
   output logic      sync_out
);

   logic meta_q;
   logic sync_q;

   // Two flops; only the second stage is ever read outside.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;

endmodule
